// >>> include/dside_pkg.sv
// constants and types shared by the data-side local memory port
// assumes big-endian bit 0 of the control register is its msb
package dside_pkg;
   localparam int CPU_ADDR_W  = 32;
   localparam int REGION_W    = 8;
   localparam int CTRL_W      = 8;
   localparam int MEM_ADDR_W  = 22;
   localparam int MEM_ADDR_LO = 2;
   localparam int DATA_W      = 32;
   localparam int BE_W        = 4;
   localparam int CFG_ADDR_W  = 10;
   localparam int OLD_TIE_W   = 8;
   localparam int NEW_TIE_W   = 6;
   // low address bits of the two configuration registers
   localparam logic [1:0] CFG_REGION_LOW_OLD = 2'h2;
   localparam logic [1:0] CFG_CTRL_LOW_OLD   = 2'h3;
   localparam logic [3:0] CFG_REGION_LOW_NEW = 4'h6;
   localparam logic [3:0] CFG_CTRL_LOW_NEW   = 4'h7;
   // decoder enable sits in big-endian bit 0
   localparam int CTRL_DEC_EN_BIT = 7;
   localparam logic [CTRL_W-1:0]   CTRL_RST   = 8'h00;
   localparam logic [REGION_W-1:0] REGION_RST = 8'h00;
   // legal core to memory clock ratios, kept by the clock source
   localparam int RATIO_MAX_NEW = 8;
   localparam int RATIO_MAX_OLD = 4;

   typedef enum logic [1:0] {
      MEM_IDLE = 2'b01,
      MEM_WAIT = 2'b10
   } mem_state_t;
endpackage : dside_pkg

// >>> rtl/bit_sync.sv
// two-flop level synchroniser
// assumes the input is a level held for several destination cycles
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b0;
         q_o    <= 1'b0;
      end else begin
         meta_q <= d_i;
         q_o    <= meta_q;
      end
   end
endmodule : bit_sync
`default_nettype wire

// >>> rtl/dside_local_mem_port.sv
// data-side local memory port: core-side decode and one memory-clock access engine
// assumes the tie-off inputs are static; the memory clock may run at any phase
// Notes on behaviour
// R1: memory-side controller logic runs on the dedicated memory clock.
// R2: clock ratio is 1..8 on newer parts, 1..4 on older ones.
// R3: outside clocking keeps both clocks integer related, rising edges aligned; the port does not rely on this and synchronises both crossings.
// R4: read data returns on a 32-bit bus from memory or peripheral.
// R5: an access may last any number of memory cycles until completion.
// R6: the attached module pulses completion for exactly one memory cycle.
// R7: read data is valid in the same cycle as the completion pulse.
// R8: after completion the controller may issue the next pending access.
// R9: no timeout here; attached logic must always answer.
// R10: completion tied high when latency is always one.
// R11: control register takes its init value at power-up; writes overwrite.
// R12: region register takes its init value at power-up.
// R13: tie-offs initialise registers at power-up and every processor reset.
// R14: older variant: 8-bit tie plus low bits 10 and 11.
// R15: newer variant: 6-bit shared tie plus low nibble 0110 and 0111.
// R16: top eight address bits compared with region register for a hit.
// R17: decoding only when the control decode-enable bit is set.
// R18: a load wins over a store when both want the port.
// R19: one access outstanding; stray completion pulses are ignored.
`timescale 1ns/1ps
`default_nettype none
module dside_local_mem_port #(
   parameter bit NEWER_VARIANT = 1'b1
) (
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   input  wire logic                                dside_mem_clk_i,
   input  wire logic                                ld_valid_i,
   input  wire logic [dside_pkg::CPU_ADDR_W-1:0]    ld_addr_i,
   input  wire logic                                st_valid_i,
   input  wire logic [dside_pkg::CPU_ADDR_W-1:0]    st_addr_i,
   input  wire logic [dside_pkg::DATA_W-1:0]        st_data_i,
   input  wire logic [dside_pkg::BE_W-1:0]          st_be_i,
   output logic                                     port_ready_o,
   output logic                                     ld_done_o,
   output logic                                     st_done_o,
   output logic                                     ld_miss_o,
   output logic                                     st_miss_o,
   output logic [dside_pkg::DATA_W-1:0]             ld_data_o,
   input  wire logic                                cfg_wr_i,
   input  wire logic                                cfg_rd_i,
   input  wire logic [dside_pkg::CFG_ADDR_W-1:0]    cfg_addr_i,
   input  wire logic [dside_pkg::CTRL_W-1:0]        cfg_wdata_i,
   output logic [dside_pkg::CTRL_W-1:0]             cfg_rdata_o,
   output logic                                     cfg_ack_o,
   input  wire logic [dside_pkg::CTRL_W-1:0]        dside_ctrl_init_value_i,
   input  wire logic [dside_pkg::REGION_W-1:0]      dside_region_init_value_i,
   input  wire logic [dside_pkg::OLD_TIE_W-1:0]     dside_cfgbus_addr_tie_i,
   input  wire logic [dside_pkg::NEW_TIE_W-1:0]     shared_cfgbus_addr_tie_i,
   output logic [dside_pkg::CTRL_W-1:0]             dside_ctrl_reg_o,
   output logic [dside_pkg::REGION_W-1:0]           dside_region_reg_o,
   input  wire logic [dside_pkg::DATA_W-1:0]        dside_read_data_bus_i,
   input  wire logic                                dside_access_done_i,
   output logic                                     dside_mem_enable_o,
   output logic [dside_pkg::MEM_ADDR_W-1:0]         mem_addr_o,
   output logic [dside_pkg::DATA_W-1:0]             mem_wr_data_o,
   output logic [dside_pkg::BE_W-1:0]               mem_byte_wr_o,
   output logic                                     rd_addr_valid_o,
   output logic                                     wr_addr_valid_o
);
   // ****************************************
   // configuration registers
   // ****************************************
   logic init_q;
   logic cfg_region_hit;
   logic cfg_ctrl_hit;

   // R14: older variant address map
   // R15: newer variant address map
   always_comb begin
      if (NEWER_VARIANT) begin
         cfg_region_hit = cfg_addr_i == {shared_cfgbus_addr_tie_i, dside_pkg::CFG_REGION_LOW_NEW};
         cfg_ctrl_hit   = cfg_addr_i == {shared_cfgbus_addr_tie_i, dside_pkg::CFG_CTRL_LOW_NEW};
      end else begin
         cfg_region_hit = cfg_addr_i == {dside_cfgbus_addr_tie_i, dside_pkg::CFG_REGION_LOW_OLD};
         cfg_ctrl_hit   = cfg_addr_i == {dside_cfgbus_addr_tie_i, dside_pkg::CFG_CTRL_LOW_OLD};
      end
   end

   // reset may only load constants, so ties are taken on the first edge after release
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         init_q <= 1'b1;
      end else begin
         init_q <= 1'b0;
      end
   end

   // R11: control init then software writes
   // R12: region init
   // R13: reloaded after every reset
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         dside_ctrl_reg_o   <= dside_pkg::CTRL_RST;
         dside_region_reg_o <= dside_pkg::REGION_RST;
      end else if (init_q) begin
         dside_ctrl_reg_o   <= dside_ctrl_init_value_i;
         dside_region_reg_o <= dside_region_init_value_i;
      end else if (cfg_wr_i) begin
         if (cfg_ctrl_hit) begin
            dside_ctrl_reg_o <= cfg_wdata_i;
         end
         if (cfg_region_hit) begin
            dside_region_reg_o <= cfg_wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_ack_o   <= 1'b0;
         cfg_rdata_o <= dside_pkg::CTRL_RST;
      end else begin
         cfg_ack_o   <= (cfg_wr_i | cfg_rd_i) & (cfg_ctrl_hit | cfg_region_hit);
         cfg_rdata_o <= cfg_ctrl_hit ? dside_ctrl_reg_o :
                        (cfg_region_hit ? dside_region_reg_o : dside_pkg::CTRL_RST);
      end
   end

   // ****************************************
   // core side decode and request launch
   // ****************************************
   logic                              take;
   logic                              hit;
   logic [dside_pkg::CPU_ADDR_W-1:0]  sel_addr;
   logic                              req_tog_q;
   logic                              req_wr_q;
   logic [dside_pkg::CPU_ADDR_W-1:0]  req_addr_q;
   logic [dside_pkg::DATA_W-1:0]      req_data_q;
   logic [dside_pkg::BE_W-1:0]        req_be_q;
   logic                              ack_sync;
   logic                              ack_seen_q;
   logic                              ack_tog_m_q;
   logic [dside_pkg::DATA_W-1:0]      rdata_m_q;

   // R18: load first
   assign sel_addr = ld_valid_i ? ld_addr_i : st_addr_i;
   // R16: region compare
   // R17: decoder enable gate
   assign hit  = dside_ctrl_reg_o[dside_pkg::CTRL_DEC_EN_BIT] &&
                 (sel_addr[dside_pkg::CPU_ADDR_W-1 -: dside_pkg::REGION_W] == dside_region_reg_o);
   assign take = port_ready_o & (ld_valid_i | st_valid_i) & ~init_q;

   // R19: ready drops while an access is outstanding
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         port_ready_o <= 1'b0;
      end else if (init_q) begin
         port_ready_o <= 1'b1;
      end else if (take && hit) begin
         port_ready_o <= 1'b0;
      end else if (ack_sync != ack_seen_q) begin
         port_ready_o <= 1'b1;
      end
   end

   // request words stay frozen until the answer returns, so the far side may sample them late
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_tog_q  <= 1'b0;
         req_wr_q   <= 1'b0;
         req_addr_q <= '0;
         req_data_q <= '0;
         req_be_q   <= '0;
      end else if (take && hit) begin
         req_tog_q  <= ~req_tog_q;
         req_wr_q   <= ~ld_valid_i;
         req_addr_q <= sel_addr;
         req_data_q <= st_data_i;
         req_be_q   <= st_be_i;
      end
   end

   bit_sync u_ack_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (ack_tog_m_q),
      .q_o   (ack_sync)
   );

   // R8: answer ends the transaction
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_seen_q <= 1'b0;
         ld_done_o  <= 1'b0;
         st_done_o  <= 1'b0;
         ld_miss_o  <= 1'b0;
         st_miss_o  <= 1'b0;
         ld_data_o  <= '0;
      end else begin
         ack_seen_q <= ack_sync;
         ld_done_o  <= (ack_sync != ack_seen_q) & ~req_wr_q;
         st_done_o  <= (ack_sync != ack_seen_q) & req_wr_q;
         ld_miss_o  <= take & ~hit & ld_valid_i;
         st_miss_o  <= take & ~hit & ~ld_valid_i;
         if ((ack_sync != ack_seen_q) && !req_wr_q) begin
            ld_data_o <= rdata_m_q;
         end
      end
   end

   // ****************************************
   // memory clock side access engine
   // ****************************************
   dside_pkg::mem_state_t state_q;
   logic                  req_sync;
   logic                  req_seen_m_q;
   logic                  new_req;

   bit_sync u_req_sync (
      .clk_i (dside_mem_clk_i),
      .rst_i (rst_i),
      .d_i   (req_tog_q),
      .q_o   (req_sync)
   );

   assign new_req = req_sync != req_seen_m_q;

   // R1: engine on the memory clock
   // R5: wait any number of cycles for completion
   always_ff @(posedge dside_mem_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q      <= dside_pkg::MEM_IDLE;
         req_seen_m_q <= 1'b0;
         ack_tog_m_q  <= 1'b0;
      end else begin
         case (state_q)
            dside_pkg::MEM_IDLE: begin
               if (new_req) begin
                  req_seen_m_q <= req_sync;
                  state_q      <= dside_pkg::MEM_WAIT;
               end
            end
            dside_pkg::MEM_WAIT: begin
               if (dside_access_done_i) begin
                  ack_tog_m_q <= ~ack_tog_m_q;
                  state_q     <= dside_pkg::MEM_IDLE;
               end
            end
            default: begin
               state_q <= dside_pkg::MEM_IDLE;
            end
         endcase
      end
   end

   // strobes last one memory cycle; address and data hold for the slave to register
   always_ff @(posedge dside_mem_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dside_mem_enable_o <= 1'b0;
         rd_addr_valid_o    <= 1'b0;
         wr_addr_valid_o    <= 1'b0;
         mem_byte_wr_o      <= '0;
         mem_addr_o         <= '0;
         mem_wr_data_o      <= '0;
      end else begin
         dside_mem_enable_o <= (state_q == dside_pkg::MEM_IDLE) & new_req;
         rd_addr_valid_o    <= (state_q == dside_pkg::MEM_IDLE) & new_req & ~req_wr_q;
         wr_addr_valid_o    <= (state_q == dside_pkg::MEM_IDLE) & new_req & req_wr_q;
         mem_byte_wr_o      <= ((state_q == dside_pkg::MEM_IDLE) & new_req & req_wr_q) ?
                               req_be_q : '0;
         if ((state_q == dside_pkg::MEM_IDLE) && new_req) begin
            mem_addr_o    <= req_addr_q[dside_pkg::MEM_ADDR_LO +: dside_pkg::MEM_ADDR_W];
            mem_wr_data_o <= req_data_q;
         end
      end
   end

   // R7: read data taken with the completion pulse
   always_ff @(posedge dside_mem_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_m_q <= '0;
      end else if (state_q == dside_pkg::MEM_WAIT && dside_access_done_i && !req_wr_q) begin
         rdata_m_q <= dside_read_data_bus_i;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence wait_done_s;
      state_q == dside_pkg::MEM_WAIT && dside_access_done_i;
   endsequence

   // the release edge still sees reset in the logic, so check once the init cycle has ended
   init_load_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11 R12 R13
      $fell(init_q) |-> dside_ctrl_reg_o == $past(dside_ctrl_init_value_i) &&
                        dside_region_reg_o == $past(dside_region_init_value_i))
      else $error("registers not loaded from tie-offs");
   strobe_kind_a: assert property (@(posedge dside_mem_clk_i) disable iff (rst_i) // R1
      dside_mem_enable_o |-> rd_addr_valid_o != wr_addr_valid_o)
      else $error("access strobe without exactly one kind");
   cfg_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14 R15
      !init_q && cfg_wr_i && cfg_ctrl_hit |=> dside_ctrl_reg_o == $past(cfg_wdata_i))
      else $error("control register write lost");
   load_prio_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
      take && hit && ld_valid_i && st_valid_i |=> !port_ready_o && !req_wr_q)
      else $error("store taken over load");
   miss_report_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16 R17
      take && !hit |=> port_ready_o && (ld_miss_o || st_miss_o) && $stable(req_tog_q))
      else $error("miss not reported");
   one_outstanding_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
      !port_ready_o |=> $stable(req_tog_q))
      else $error("second access launched");
   en_pulse_a: assert property (@(posedge dside_mem_clk_i) disable iff (rst_i) // R5
      dside_mem_enable_o |-> state_q == dside_pkg::MEM_WAIT ##1 !dside_mem_enable_o)
      else $error("enable longer than one cycle");
   done_ends_a: assert property (@(posedge dside_mem_clk_i) disable iff (rst_i) // R8
      wait_done_s |=> state_q == dside_pkg::MEM_IDLE && ack_tog_m_q != $past(ack_tog_m_q))
      else $error("completion did not end access");
   stray_done_a: assert property (@(posedge dside_mem_clk_i) disable iff (rst_i) // R19
      state_q == dside_pkg::MEM_IDLE && dside_access_done_i |=> $stable(ack_tog_m_q))
      else $error("stray completion acted on");
   rdata_cap_a: assert property (@(posedge dside_mem_clk_i) disable iff (rst_i) // R7
      wait_done_s and !req_wr_q |=> rdata_m_q == $past(dside_read_data_bus_i))
      else $error("read data not captured with completion");
endmodule : dside_local_mem_port
`default_nettype wire

// >>> tb/mem_model.sv
// memory-side partner of the port: answers each access after a set delay
// assumes the port and this model share the memory clock
`timescale 1ns/1ps
`default_nettype none
module mem_model (
   input  wire logic        clk_i,
   input  wire logic        en_i,
   input  wire logic        wr_i,
   input  wire logic [21:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  be_i,
   input  wire logic        tie_high_i,
   input  wire logic [3:0]  lat_i,
   output logic [31:0]      rdata_o,
   output logic             done_o
);
   // ***************
   // access engine
   // ***************
   logic [31:0] rdata_q = 32'h0;
   logic        done_q  = 1'b0;
   logic        busy_q  = 1'b0;
   logic [3:0]  cnt_q   = 4'h0;
   logic [21:0] addr_q  = 22'h0;
   logic [31:0] wdata_q = 32'h0;
   logic [3:0]  be_q    = 4'h0;
   assign rdata_o = tie_high_i ? {10'h2A5, addr_i} : rdata_q;
   assign done_o  = tie_high_i | done_q;
   // each access answered lat_i+1 cycles after the enable, or at once while tie_high_i is set
   always @(posedge clk_i) begin
      done_q  <= 1'b0;
      rdata_q <= ~rdata_q;
      if (en_i) begin
         addr_q <= addr_i;
         if (wr_i) begin
            wdata_q <= wdata_i;
            be_q    <= be_i;
         end
         busy_q <= !tie_high_i;
         cnt_q  <= lat_i;
      end else if (busy_q) begin
         if (cnt_q == 4'h0) begin
            done_q  <= 1'b1;
            rdata_q <= {10'h2A5, addr_q};
            busy_q  <= 1'b0;
         end else begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule : mem_model
`default_nettype wire

// >>> tb/data_side_local_mem_port_test.sv
// self-checking bench for the data-side local memory port
// assumes the newer variant and a free-running 30 ns memory clock
`timescale 1ns/1ps
`default_nettype none
module data_side_local_mem_port_test;
   logic clk = 1'b0, mclk = 1'b0, rst = 1'b1, ldv = 1'b0, stv = 1'b0;
   logic cwr = 1'b0, crd = 1'b0, tieh = 1'b0, rdy, ldd, std, ldm, stm, ack;
   logic en, rav, wav, done;
   logic [31:0] lda = 32'h0, sta = 32'h0, std_d = 32'h0, ldo, rdat, wdo;
   logic [9:0]  cad = 10'h0;
   logic [7:0]  cwd = 8'h0, crdo, ctl, reg_o;
   logic [21:0] maddr;
   logic [3:0]  be = 4'h0, mbe, lat = 4'h0;
   int bad_count = 0, check_count = 0;
   always #2 clk = ~clk;
   // memory clock source
   // free phase on purpose: the crossings must not rely on edge alignment
   initial #3 forever #15 mclk = ~mclk;
   dside_local_mem_port i_dside_local_mem_port (.clk_i(clk), .rst_i(rst),
      .dside_mem_clk_i(mclk), .ld_valid_i(ldv), .ld_addr_i(lda), .st_valid_i(stv),
      .st_addr_i(sta), .st_data_i(std_d), .st_be_i(be), .port_ready_o(rdy),
      .ld_done_o(ldd), .st_done_o(std), .ld_miss_o(ldm), .st_miss_o(stm),
      .ld_data_o(ldo), .cfg_wr_i(cwr), .cfg_rd_i(crd), .cfg_addr_i(cad),
      .cfg_wdata_i(cwd), .cfg_rdata_o(crdo), .cfg_ack_o(ack),
      .dside_ctrl_init_value_i(8'h80), .dside_region_init_value_i(8'h12),
      .dside_cfgbus_addr_tie_i(8'h3C), .shared_cfgbus_addr_tie_i(6'h05),
      .dside_ctrl_reg_o(ctl), .dside_region_reg_o(reg_o),
      .dside_read_data_bus_i(rdat), .dside_access_done_i(done),
      .dside_mem_enable_o(en), .mem_addr_o(maddr), .mem_wr_data_o(wdo),
      .mem_byte_wr_o(mbe), .rd_addr_valid_o(rav), .wr_addr_valid_o(wav));
   mem_model i_mem_model (.clk_i(mclk), .en_i(en), .wr_i(wav), .addr_i(maddr),
      .wdata_i(wdo), .be_i(mbe), .tie_high_i(tieh), .lat_i(lat), .rdata_o(rdat),
      .done_o(done));
   // ***************
   // shared tasks
   // ***************
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %0t seen %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic do_reset;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : do_reset
   task automatic cfg(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic k, output logic [7:0] r);
      cwr <= w;
      crd <= !w;
      cad <= a;
      cwd <= d;
      @(posedge clk);
      cwr <= 1'b0;
      crd <= 1'b0;
      @(negedge clk);
      k = ack;
      r = crdo;
      @(posedge clk);
   endtask : cfg
   task automatic req(input logic ld, input logic [31:0] a, output logic d,
                      output logic m);
      logic r;
      int n;
      if (ld) ldv <= 1'b1; else stv <= 1'b1;
      if (ld) lda <= a; else sta <= a;
      do begin @(negedge clk); r = rdy; @(posedge clk); end while (!r);
      ldv <= 1'b0;
      stv <= 1'b0;
      d = 1'b0;
      m = 1'b0;
      n = 0;
      while (!d && !m && n < 300) begin
         @(negedge clk);
         d = ld ? ldd : std;
         m = ld ? ldm : stm;
         n++;
      end
      @(posedge clk);
   endtask : req
   // ***************
   // scenarios
   // ***************
   task automatic t_cfg;
      logic k;
      logic [7:0] r;
      chk(ctl, 8'h80);
      chk(reg_o, 8'h12);
      cfg(1'b0, {6'h05, 4'h6}, 8'h0, k, r);
      chk({k, r}, {1'b1, 8'h12});
      cfg(1'b0, {6'h05, 4'h7}, 8'h0, k, r);
      chk({k, r}, {1'b1, 8'h80});
      cfg(1'b0, {6'h05, 4'h8}, 8'h0, k, r);
      chk(k, 1'b0);
      $display("test cfg done");
   endtask : t_cfg
   task automatic t_load(input logic [3:0] l);
      logic d, m;
      lat <= l;
      req(1'b1, 32'h1200_0104, d, m);
      chk({d, m}, 2'b10);
      chk(ldo, {10'h2A5, 22'h000041});
      chk(i_mem_model.addr_q, 22'h000041);
      req(1'b1, 32'h12FF_FFFC, d, m);
      chk(ldo, {10'h2A5, 22'h3FFFFF});
      $display("test load latency %0d done", l);
   endtask : t_load
   task automatic t_store;
      logic d, m;
      tieh <= 1'b1;
      std_d <= 32'hCAFE_0123;
      be <= 4'hA;
      req(1'b0, 32'h1200_0208, d, m);
      chk({d, m}, 2'b10);
      chk({i_mem_model.wdata_q, i_mem_model.be_q}, {32'hCAFE_0123, 4'hA});
      tieh <= 1'b0;
      $display("test store done");
   endtask : t_store
   task automatic t_miss;
      logic d, m, k;
      logic [7:0] r;
      req(1'b1, 32'h1300_0000, d, m);
      chk({d, m}, 2'b01);
      cfg(1'b1, {6'h05, 4'h7}, 8'h00, k, r);
      req(1'b0, 32'h1200_0000, d, m);
      chk({d, m}, 2'b01);
      cfg(1'b1, {6'h05, 4'h7}, 8'h80, k, r);
      chk(ctl, 8'h80);
      $display("test miss done");
   endtask : t_miss
   task automatic t_prio;
      logic d, m;
      lat <= 4'h2;
      sta <= 32'h1200_0300;
      stv <= 1'b1;
      req(1'b1, 32'h1200_0400, d, m);
      chk({d, std}, 2'b10);
      req(1'b0, 32'h1200_0300, d, m);
      chk(d, 1'b1);
      $display("test priority done");
   endtask : t_prio
   task automatic t_rereset;
      logic k;
      logic [7:0] r;
      cfg(1'b1, {6'h05, 4'h6}, 8'h55, k, r);
      chk(reg_o, 8'h55);
      do_reset();
      chk({ctl, reg_o}, 16'h8012);
      $display("test second reset done");
   endtask : t_rereset
   initial begin
      do_reset();
      t_cfg();
      t_load(4'h0);
      t_load(4'h5);
      t_store();
      t_miss();
      t_prio();
      t_rereset();
      wrap_up();
   end
   // limit reckoned at roughly a hundred times the expected run
   initial begin
      #200000;
      bad_count++;
      wrap_up();
   end
endmodule : data_side_local_mem_port_test
`default_nettype wire
